// ===== src/sbl_defs.vh
// Constants for the serial boot loader: offsets, codes, windows and timing
`ifndef SBL_DEFS_VH
`define SBL_DEFS_VH
// Register byte offsets on the APB slave
`define SBL_REG_CTRL      8'h00
`define SBL_REG_STATUS    8'h04
`define SBL_REG_BITRATE   8'h08
`define SBL_REG_LENGTH    8'h0C
`define SBL_REG_RAMADDR   8'h10
`define SBL_REG_RAMDATA   8'h14
`define SBL_REG_JUMPADDR  8'h18
// Control field positions and reset value
`define SBL_CTRL_RXEN     0
`define SBL_CTRL_TXEN     1
`define SBL_CTRL_RESET    2'h0
// Handshake byte codes
`define SBL_BYTE_SYNC     8'h00
`define SBL_BYTE_ASK      8'h55
`define SBL_BYTE_ACK      8'hAA
`define SBL_BYTE_ERR      8'hFF
// Load window, reserved area and entry points
`define SBL_LOAD_BYTES    12'hC00
`define SBL_RSVD_BYTES    12'h3F0
`define SBL_BASE_LOW      24'h0FF300
`define SBL_BASE_HIGH     24'hFFF300
`define SBL_RSVD_LOW      24'h0FEF10
`define SBL_RSVD_HIGH     24'hFFEF10
// Frame length seen as one low stretch: start bit plus eight zeros
`define SBL_LOW_BITS      9
// Settling time after reset, in states (one state per clock)
`define SBL_WAKE_STATES   100
`endif

// ===== src/sbl_serial_boot_loader.v
// Serial boot loader: mode select, bit-rate alignment, erase check, program download
`timescale 1ns/1ps
`include "sbl_defs.vh"

module sbl_serial_boot_loader #(
    parameter CNT_W = 20
) (
    input  wire              clock,
    input  wire              rst,
    input  wire              ce,
    input  wire [7:0]        paddr,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    input  wire              vppHigh,
    input  wire              modePinTwoHigh,
    input  wire              modePinTwo,
    input  wire              modePinOne,
    input  wire              modePinZero,
    input  wire              bootReceiveLine,
    output reg               bootTransmitLine,
    input  wire              flashBlank,
    output reg               eraseStart,
    input  wire              eraseDone,
    input  wire              eraseFail,
    output reg               bootMode,
    output reg               userProgMode,
    output reg               jumpValid,
    output reg  [23:0]       jumpAddr
);
    // Boot sequencer states
    localparam ST_IDLE  = 4'd0;
    localparam ST_WAKE  = 4'd1;
    localparam ST_HIGH  = 4'd2;
    localparam ST_MEAS  = 4'd3;
    localparam ST_SYNC  = 4'd4;
    localparam ST_ASK   = 4'd5;
    localparam ST_CHECK = 4'd6;
    localparam ST_ERASE = 4'd7;
    localparam ST_ACK   = 4'd8;
    localparam ST_LENHI = 4'd9;
    localparam ST_LENLO = 4'd10;
    localparam ST_DATA  = 4'd11;
    localparam ST_DRAIN = 4'd12;
    localparam ST_JUMP  = 4'd13;
    localparam ST_HALT  = 4'd14;

    // Two-stage synchronisers for every pin input
    reg [5:0]       pinMeta, pinSync;
    wire            rxIn       = pinSync[0];
    wire            vppIn      = pinSync[1];
    wire            md2HighIn  = pinSync[2];
    wire            md2In      = pinSync[3];
    wire [1:0]      mdLowIn    = pinSync[5:4];
    reg             modeCaught, eraseError, rxBusy, rxDone, txBusy, txReq;
    reg [2:0]       modeNum;
    reg [3:0]       state, rxIdx, txIdx;
    reg [6:0]       wakeCnt;
    reg [CNT_W-1:0] lowCount, bitRate, rxCnt, txCnt;
    reg [1:0]       ctrl;
    reg [15:0]      progLen, rxCount;
    reg [11:0]      ramAddr;
    reg [7:0]       ramMem [0:3071];
    reg [7:0]       rxShift, txByte;
    reg [9:0]       txShift;
    // Quotient kept at full width so the cut to the bit-rate width is explicit
    wire [31:0]     lowPerBit = lowCount / `SBL_LOW_BITS;
    wire rxEn = ctrl[`SBL_CTRL_RXEN];
    wire txEn = ctrl[`SBL_CTRL_TXEN];
    // APB: zero-wait answer, error on unmapped offsets
    wire apbWrite = psel & penable & pwrite;
    wire mapped   = (paddr <= `SBL_REG_JUMPADDR) && (paddr[1:0] == 2'b00); // Map is dense words from zero
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Pins cross into the clock domain before anything looks at them
    always @(posedge clock) begin
        if (rst) begin
            pinMeta <= 6'h3F;
            pinSync <= 6'h3F;
        end else if (ce) begin
            pinMeta <= {modePinOne, modePinZero, modePinTwo, modePinTwoHigh, vppHigh, bootReceiveLine};
            pinSync <= pinMeta;
        end
    end

    // Mode is caught once after reset release, so pin changes later do not disturb it
    always @(posedge clock) begin
        if (rst) begin
            modeCaught   <= 1'b0;
            modeNum      <= 3'd0;
            bootMode     <= 1'b0;
            userProgMode <= 1'b0;
        end else if (ce && !modeCaught && wakeCnt == 7'd2) begin
            modeCaught   <= 1'b1;
            modeNum      <= {1'b1, mdLowIn};
            bootMode     <= vppIn & md2HighIn & (mdLowIn != 2'b00);
            userProgMode <= vppIn & md2In & ~md2HighIn & (mdLowIn != 2'b00);
        end
    end

    // Receiver: samples mid-bit using the aligned bit length
    always @(posedge clock) begin
        if (rst) begin
            rxBusy  <= 1'b0;
            rxCnt   <= {CNT_W{1'b0}};
            rxIdx   <= 4'd0;
            rxShift <= 8'h00;
            rxDone  <= 1'b0;
        end else if (ce) begin
            rxDone <= 1'b0;
            if (!rxBusy) begin
                if (rxEn && !rxIn && state > ST_MEAS) begin
                    rxBusy <= 1'b1;
                    rxCnt  <= bitRate >> 1;
                    rxIdx  <= 4'd0;
                end
            end else if (rxCnt != {CNT_W{1'b0}}) begin
                rxCnt <= rxCnt - 1'b1;
            end else begin
                rxCnt <= bitRate;
                rxIdx <= rxIdx + 1'b1;
                if (rxIdx == 4'd0 && rxIn) begin
                    rxBusy <= 1'b0; // Glitch, not a start bit
                end else if (rxIdx == 4'd9) begin
                    rxBusy <= 1'b0;
                    rxDone <= rxIn; // Framing error drops the byte
                end else if (rxIdx != 4'd0) begin
                    rxShift <= {rxIn, rxShift[7:1]};
                end
            end
        end
    end

    // Transmitter: line idles high, and stays high once serial is off
    always @(posedge clock) begin
        if (rst) begin
            txBusy           <= 1'b0;
            txCnt            <= {CNT_W{1'b0}};
            txIdx            <= 4'd0;
            txShift          <= 10'h3FF;
            bootTransmitLine <= 1'b1;
        end else if (ce) begin
            if (!txBusy) begin
                bootTransmitLine <= 1'b1;
                if (txReq && txEn) begin
                    txBusy  <= 1'b1;
                    txShift <= {1'b1, txByte, 1'b0};
                    txCnt   <= bitRate;
                    txIdx   <= 4'd0;
                    bootTransmitLine <= 1'b0;
                end
            end else if (txCnt != {CNT_W{1'b0}}) begin
                txCnt <= txCnt - 1'b1;
            end else if (txIdx == 4'd9) begin
                txBusy <= 1'b0;
                bootTransmitLine <= 1'b1;
            end else begin
                txCnt   <= bitRate;
                txIdx   <= txIdx + 1'b1;
                txShift <= {1'b1, txShift[9:1]};
                bootTransmitLine <= txShift[1];
            end
        end
    end

    // Boot sequencer, control bits and load memory share one process
    always @(posedge clock) begin
        if (rst) begin
            state      <= ST_IDLE;
            wakeCnt    <= 7'd0;
            lowCount   <= {CNT_W{1'b0}};
            bitRate    <= {CNT_W{1'b0}};
            ctrl       <= `SBL_CTRL_RESET;
            progLen    <= 16'h0000;
            rxCount    <= 16'h0000;
            eraseError <= 1'b0;
            eraseStart <= 1'b0;
            txReq      <= 1'b0;
            txByte     <= 8'h00;
            ramAddr    <= 12'h000;
            jumpValid  <= 1'b0;
            jumpAddr   <= 24'h000000;
        end else if (ce) begin
            eraseStart <= 1'b0;
            if (txReq && txEn && !txBusy) begin
                txReq <= 1'b0;
            end
            // Software may steer the serial enables and the memory peek pointer
            if (apbWrite && paddr == `SBL_REG_CTRL) begin
                ctrl <= pwdata[1:0];
            end
            if (apbWrite && paddr == `SBL_REG_RAMADDR) begin
                ramAddr <= pwdata[11:0];
            end
            case (state)
                ST_IDLE: begin
                    if (modeCaught && bootMode) begin
                        state <= ST_WAKE;
                    end else if (!modeCaught) begin
                        wakeCnt <= wakeCnt + 1'b1;
                    end
                end
                ST_WAKE: begin
                    // Settling time before the first low period may be timed
                    if (wakeCnt >= `SBL_WAKE_STATES) begin
                        state <= ST_HIGH;
                    end else begin
                        wakeCnt <= wakeCnt + 1'b1;
                    end
                end
                ST_HIGH: begin
                    // A line already low would give a short, wrong measurement
                    if (rxIn) begin
                        state    <= ST_MEAS;
                        lowCount <= {CNT_W{1'b0}};
                    end
                end
                ST_MEAS: begin
                    if (!rxIn) begin
                        if (lowCount != {CNT_W{1'b1}}) begin
                            lowCount <= lowCount + 1'b1;
                        end
                    end else if (lowCount != {CNT_W{1'b0}}) begin
                        // Divide by nine bits; truncation error is small only in the allowed clock ranges
                        bitRate <= lowPerBit[CNT_W-1:0] - 1'b1;
                        ctrl    <= 2'b11;
                        txByte  <= `SBL_BYTE_SYNC;
                        txReq   <= 1'b1;
                        state   <= ST_SYNC;
                    end
                end
                ST_SYNC, ST_ACK, ST_DRAIN: begin
                    // Each answer, and the last echo before serial is switched off, must leave first
                    if (!txReq && !txBusy) begin
                        state <= state + 4'd1; // Each wait state is followed by the next code
                    end
                end
                ST_ASK: begin
                    // Trailing zero bytes from the host are ignored here
                    if (rxDone && rxShift == `SBL_BYTE_ASK) begin
                        txByte <= `SBL_BYTE_ACK;
                        txReq  <= 1'b1;
                        state  <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (!txReq && !txBusy) begin
                        if (flashBlank) begin
                            txByte <= `SBL_BYTE_ACK;
                            txReq  <= 1'b1;
                            state  <= ST_ACK;
                        end else begin
                            eraseStart <= 1'b1;
                            state      <= ST_ERASE;
                        end
                    end
                end
                ST_ERASE: begin
                    if (eraseFail) begin
                        eraseError <= 1'b1;
                        txByte     <= `SBL_BYTE_ERR;
                        txReq      <= 1'b1;
                        state      <= ST_HALT;
                    end else if (eraseDone) begin
                        txByte <= `SBL_BYTE_ACK;
                        txReq  <= 1'b1;
                        state  <= ST_ACK;
                    end
                end
                ST_LENHI: begin
                    if (rxDone) begin
                        progLen[15:8] <= rxShift;
                        txByte <= rxShift;
                        txReq  <= 1'b1;
                        state  <= ST_LENLO;
                    end
                end
                ST_LENLO: begin
                    if (rxDone) begin
                        progLen[7:0] <= rxShift;
                        txByte  <= rxShift;
                        txReq   <= 1'b1;
                        rxCount <= 16'h0000;
                        state   <= ({progLen[15:8], rxShift} == 16'h0000) ? ST_DRAIN : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rxDone) begin
                        // Bytes past the window are echoed but dropped, guarding the reserved area
                        if (rxCount < {4'h0, `SBL_LOAD_BYTES}) begin
                            ramMem[rxCount[11:0]] <= rxShift;
                        end
                        txByte  <= rxShift;
                        txReq   <= 1'b1;
                        rxCount <= rxCount + 1'b1;
                        if (rxCount + 1'b1 == progLen) begin
                            state <= ST_DRAIN;
                        end
                    end
                end
                ST_JUMP: begin
                    ctrl      <= 2'b00;
                    jumpValid <= 1'b1;
                    jumpAddr  <= (modeNum == 3'd7) ? `SBL_BASE_HIGH : `SBL_BASE_LOW;
                end
                default: begin
                    // Halted after an erase error; only reset leaves here
                    if (!txReq && !txBusy) begin
                        ctrl <= 2'b00;
                    end
                end
            endcase
        end
    end

    // Read data is registered in the setup phase and shown in the access phase
    always @(posedge clock) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (ce && psel && !penable) begin
            if (paddr == `SBL_REG_CTRL) begin
                prdata <= {30'h0, ctrl};
            end else if (paddr == `SBL_REG_STATUS) begin
                prdata <= {21'h0, jumpValid, eraseError, userProgMode, bootMode, modeNum, state};
            end else if (paddr == `SBL_REG_BITRATE) begin
                prdata <= {{(32-CNT_W){1'b0}}, bitRate};
            end else if (paddr == `SBL_REG_LENGTH) begin
                prdata <= {rxCount, progLen};
            end else if (paddr == `SBL_REG_RAMADDR) begin
                prdata <= {20'h0, ramAddr};
            end else if (paddr == `SBL_REG_RAMDATA) begin
                prdata <= {24'h0, (ramAddr < `SBL_LOAD_BYTES) ? ramMem[ramAddr] : 8'h00};
            end else if (paddr == `SBL_REG_JUMPADDR) begin
                prdata <= {8'h0, jumpAddr};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end
endmodule

// ===== bench/sbl_serial_boot_loader_assertions.sv
// Port-level assertions for the serial boot loader
`timescale 1ns/1ps
`include "sbl_defs.vh"
module sbl_boot_checker (
    input wire        clock,
    input wire        rst,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire        vppHigh,
    input wire        modePinTwoHigh,
    input wire        modePinTwo,
    input wire        modePinOne,
    input wire        modePinZero,
    input wire        bootTransmitLine,
    input wire        flashBlank,
    input wire        eraseStart,
    input wire        eraseFail,
    input wire        bootMode,
    input wire        userProgMode,
    input wire        jumpValid,
    input wire [23:0] jumpAddr
);
    reg [7:0] wakeCnt;
    reg       failSeen;
    // Cycles since reset release, saturating, and a sticky erase failure flag
    always @(posedge clock) begin
        if (rst) begin
            wakeCnt  <= 8'h00;
            failSeen <= 1'b0;
        end else begin
            wakeCnt  <= (wakeCnt == 8'hFF) ? wakeCnt : wakeCnt + 8'h01;
            failSeen <= failSeen | eraseFail;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    a_boot_select: assert property (bootMode |-> vppHigh && modePinTwoHigh && (modePinOne || modePinZero))
        else $error("boot mode without boot pin setting");
    a_user_mode: assert property (userProgMode |-> vppHigh && modePinTwo && !modePinTwoHigh && !bootMode)
        else $error("user program mode with wrong pins");
    a_tx_boot_only: assert property (!bootMode |-> bootTransmitLine)
        else $error("transmit line active outside boot mode");
    a_wake_delay: assert property (!bootTransmitLine |-> wakeCnt > 8'h64)
        else $error("transmit before wake-up delay");
    a_erase_pulse: assert property (eraseStart |=> !eraseStart)
        else $error("erase request longer than one cycle");
    a_erase_blank: assert property (eraseStart |-> !flashBlank)
        else $error("erase requested on blank flash");
    a_fail_halts: assert property (failSeen |-> !jumpValid && !eraseStart)
        else $error("activity after erase failure");
    a_jump_entry: assert property (jumpValid |-> bootTransmitLine &&
        jumpAddr == ((modePinOne && modePinZero) ? `SBL_BASE_HIGH : `SBL_BASE_LOW))
        else $error("entry address or idle line wrong at branch");
    a_ctrl_cleared: assert property (psel && penable && !pwrite && paddr == `SBL_REG_CTRL && jumpValid
        |-> prdata[1:0] == 2'b00)
        else $error("serial enables still set after branch");
    a_unmapped_err: assert property (psel && penable |-> pslverr == (paddr > `SBL_REG_JUMPADDR || paddr[1:0] != 2'b00))
        else $error("slave error flag wrong for offset");
    c_branch: cover property ($rose(jumpValid));
    c_erase: cover property (eraseStart);
    c_fail: cover property (failSeen);
    c_user: cover property (userProgMode);
endmodule
bind sbl_serial_boot_loader sbl_boot_checker i_chk (.clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr), .vppHigh(vppHigh),
    .modePinTwoHigh(modePinTwoHigh), .modePinTwo(modePinTwo), .modePinOne(modePinOne),
    .modePinZero(modePinZero), .bootTransmitLine(bootTransmitLine), .flashBlank(flashBlank),
    .eraseStart(eraseStart), .eraseFail(eraseFail), .bootMode(bootMode), .userProgMode(userProgMode),
    .jumpValid(jumpValid), .jumpAddr(jumpAddr));

// ===== bench/sbl_host_model.sv
// Host computer model on the boot serial link: 8N1 sender and receiver
`timescale 1ns/1ps
module sbl_host_model #(
    parameter BIT_CYC = 16
) (
    input  wire       clock,
    output reg        rxLine,
    input  wire       txLine,
    output reg        gotValid,
    output reg  [7:0] gotByte,
    output reg  [7:0] gotCount
);
    integer   i;
    integer   k;
    reg [7:0] sh;
    // Line idles high, as the board pull-up holds it
    initial begin
        rxLine   = 1'b1;
        gotValid = 1'b0;
        gotByte  = 8'h00;
        gotCount = 8'h00;
    end
    // One frame: start, eight bits LSB first, one stop, no parity
    task send_byte(input [7:0] b);
        begin
            for (i = 0; i < 10; i = i + 1) begin
                rxLine <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[(i + 7) % 8];
                repeat (BIT_CYC) @(posedge clock);
            end
        end
    endtask
    // Receiver samples mid-bit; a bad stop bit drops the byte like a real UART
    always begin
        @(negedge txLine);
        repeat (BIT_CYC / 2) @(posedge clock);
        for (k = 0; k < 8; k = k + 1) begin
            repeat (BIT_CYC) @(posedge clock);
            sh[k] = txLine;
        end
        repeat (BIT_CYC) @(posedge clock);
        if (txLine === 1'b1) begin
            gotByte  <= sh;
            gotValid <= 1'b1;
            gotCount <= gotCount + 8'h01;
        end
        @(posedge clock);
        gotValid <= 1'b0;
    end
endmodule

// ===== bench/tb_serial_boot_loader.sv
// Self-checking bench for the serial boot loader
`timescale 1ns/1ps
`include "sbl_defs.vh"
module tb_serial_boot_loader;
    localparam BIT_CYC = 16; // Scaled host bit time standing in for the slow host rates
    localparam LIMIT   = 40000;
    reg         clock, rst, ce, psel, penable, pwrite;
    reg  [7:0]  paddr, rxTotal;
    reg  [31:0] pwdata;
    reg         vppHigh, modePinTwoHigh, modePinTwo, modePinOne, modePinZero, flashBlank, eraseDone, eraseFail;
    wire [31:0] prdata;
    wire [23:0] jumpAddr;
    wire [7:0]  gotByte, gotCount;
    wire        pready, pslverr, bootTransmitLine, eraseStart, bootMode, userProgMode, jumpValid, gotValid, rxLine;
    reg  [7:0]  serQ[$];
    reg  [64:0] apbQ[$];
    reg  [64:0] e;
    integer     failures, checkCount, cycles, seed;

    sbl_serial_boot_loader i_dut (.clock(clock), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vppHigh(vppHigh), .modePinTwoHigh(modePinTwoHigh), .modePinTwo(modePinTwo),
        .modePinOne(modePinOne), .modePinZero(modePinZero), .bootReceiveLine(rxLine),
        .bootTransmitLine(bootTransmitLine), .flashBlank(flashBlank), .eraseStart(eraseStart),
        .eraseDone(eraseDone), .eraseFail(eraseFail), .bootMode(bootMode), .userProgMode(userProgMode),
        .jumpValid(jumpValid), .jumpAddr(jumpAddr));
    sbl_host_model #(.BIT_CYC(BIT_CYC)) i_host (.clock(clock), .rxLine(rxLine), .txLine(bootTransmitLine),
        .gotValid(gotValid), .gotByte(gotByte), .gotCount(gotCount));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Result watcher: each serial byte and APB read against the oldest note
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (gotValid === 1'b1) begin
            checkCount = checkCount + 1;
            if (serQ.size() == 0 || gotByte !== serQ[0]) begin
                failures = failures + 1;
                $display("BAD serial byte expected %h seen %h", (serQ.size() > 0) ? serQ[0] : 8'h00, gotByte);
            end
            if (serQ.size() > 0) serQ.delete(0);
        end
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            checkCount = checkCount + 1;
            e = apbQ.pop_front();
            if (pslverr !== e[64] || (prdata & e[63:32]) !== e[31:0]) begin
                failures = failures + 1;
                $display("BAD apb read %h expected %h seen %h", paddr, e[31:0], prdata & e[63:32]);
            end
        end
        if (cycles == LIMIT) begin
            failures = failures + 1;
            finish_test;
        end
    end
    task finish_test;
        begin
            if (failures == 0 && checkCount > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] ex, input [31:0] s);
        begin
            checkCount = checkCount + 1;
            if (s !== ex) begin
                failures = failures + 1;
                $display("BAD %s expected %h seen %h", nm, ex, s);
            end
        end
    endtask
    // APB transfer: hold the request until pready is seen high at an edge
    task apb(input [7:0] a, input w, input [31:0] d, input [64:0] ex);
        begin
            psel <= 1'b1;
            paddr <= a;
            pwrite <= w;
            pwdata <= d;
            if (!w) apbQ.push_back(ex);
            @(posedge clock);
            penable <= 1'b1;
            @(posedge clock);
            while (pready !== 1'b1) @(posedge clock);
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clock);
        end
    endtask
    task rd(input [7:0] a, input [31:0] m, input [31:0] v, input err);
        apb(a, 1'b0, 32'h0, {err, m, v});
    endtask
    task note(input [7:0] b);
        begin
            serQ.push_back(b);
            rxTotal = rxTotal + 8'h01;
        end
    endtask
    task waitRx;
        integer t;
        begin
            for (t = 0; t < 3000 && gotCount !== rxTotal; t = t + 1) @(negedge clock);
            chk("serial byte count", rxTotal, gotCount);
            @(posedge clock);
        end
    endtask
    task restart(input two12, input [1:0] md);
        begin
            rst <= 1'b1;
            modePinTwoHigh <= two12;
            {modePinOne, modePinZero} <= md;
            eraseDone <= 1'b0;
            eraseFail <= 1'b0;
            repeat (12) @(posedge clock);
            rst <= 1'b0;
            repeat (150) @(posedge clock); // Host line stays high through the wake-up wait
        end
    endtask
    // Full bootstrap: align, handshake, optional erase, download, branch
    task bootRun(input [1:0] md, input [15:0] len, input blank, input fail);
        integer   j;
        integer   t;
        reg [7:0] dat[0:7];
        begin
            flashBlank <= blank;
            restart(1'b1, md);
            note(`SBL_BYTE_SYNC);
            for (t = 0; t < 6 && gotCount !== rxTotal; t = t + 1) i_host.send_byte(8'h00);
            waitRx;
            rd(`SBL_REG_BITRATE, 32'hFFFFFFFF, BIT_CYC - 1, 1'b0);
            note(`SBL_BYTE_ACK);
            note(fail ? `SBL_BYTE_ERR : `SBL_BYTE_ACK);
            i_host.send_byte(`SBL_BYTE_ASK);
            if (!blank) begin
                for (t = 0; t < 2000 && eraseStart !== 1'b1; t = t + 1) @(negedge clock);
                chk("erase request", 32'h1, {31'h0, eraseStart});
                repeat ($urandom_range(60, 5)) @(posedge clock);
                eraseDone <= !fail;
                eraseFail <= fail;
            end
            waitRx;
            if (fail) begin
                repeat (200) @(posedge clock);
                rd(`SBL_REG_STATUS, 32'h00000600, 32'h00000200, 1'b0);
                rd(`SBL_REG_CTRL, 32'h00000003, 32'h0, 1'b0);
            end else begin
                note(len[15:8]);
                i_host.send_byte(len[15:8]);
                note(len[7:0]);
                i_host.send_byte(len[7:0]);
                for (j = 0; j < len; j = j + 1) begin
                    dat[j] = 8'($urandom);
                    note(dat[j]);
                    i_host.send_byte(dat[j]);
                end
                waitRx;
                for (t = 0; t < 300 && jumpValid !== 1'b1; t = t + 1) @(negedge clock);
                @(posedge clock);
                rd(`SBL_REG_STATUS, 32'h000007F0, 32'h00000480 | ((32'h4 + md) << 4), 1'b0);
                rd(`SBL_REG_JUMPADDR, 32'hFFFFFFFF, (md == 2'b11) ? `SBL_BASE_HIGH : `SBL_BASE_LOW, 1'b0);
                rd(`SBL_REG_CTRL, 32'h00000003, 32'h0, 1'b0);
                apb(`SBL_REG_BITRATE, 1'b1, 32'h0, 65'h0);
                rd(`SBL_REG_BITRATE, 32'hFFFFFFFF, BIT_CYC - 1, 1'b0);
                rd(`SBL_REG_LENGTH, 32'h0000FFFF, len, 1'b0);
                for (j = 0; j < len; j = j + 1) begin
                    apb(`SBL_REG_RAMADDR, 1'b1, j, 65'h0);
                    rd(`SBL_REG_RAMDATA, 32'h000000FF, dat[j], 1'b0);
                end
                rd(8'h1C, 32'hFFFFFFFF, 32'h0, 1'b1);
            end
        end
    endtask
    initial begin
        seed = $urandom(1);
        {rst, ce, vppHigh, modePinTwo, modePinTwoHigh} = 5'h1F;
        {psel, penable, pwrite, modePinOne, modePinZero, flashBlank, eraseDone, eraseFail} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        rxTotal = 8'h00;
        {failures, checkCount, cycles} = 96'h0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        bootRun(2'b01, 16'h0003, 1'b1, 1'b0);
        bootRun(2'b10, 16'h0000, 1'b1, 1'b0);
        bootRun(2'b11, 16'h0004, 1'b0, 1'b0);
        bootRun(2'b01, 16'h0002, 1'b0, 1'b1);
        restart(1'b0, 2'b10);
        rd(`SBL_REG_STATUS, 32'h000001F0, 32'h00000160, 1'b0);
        finish_test;
    end
endmodule
